// ===== common/adq_bus_if.sv
// memory bus between the host end and the acquisition device
`timescale 1ns/1ps
interface adq_bus_if;
	logic [15:0] addr; // byte address
	logic [7:0] wdata; // write data
	logic wr; // write strobe
	logic rd; // read strobe
	logic [7:0] rdata; // read data, cycle after rd
	logic irq; // interrupt request level
	// documented device end
	modport device (input addr, input wdata, input wr, input rd, output rdata, output irq);
	// host processor end
	modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface : adq_bus_if

// ===== common/adq_pkg.sv
// shared constants for the analog acquisition control block
package adq_pkg;
	// register offsets from the base address
	localparam logic [2:0] ADQ_OFF_CMD = 3'h0; // command write, status read
	localparam logic [2:0] ADQ_OFF_CHAN = 3'h1; // input channel select
	localparam logic [2:0] ADQ_OFF_LAST = 3'h2; // scan end channel
	localparam logic [2:0] ADQ_OFF_ICLR = 3'h3; // interrupt clear strobe
	localparam logic [2:0] ADQ_OFF_RLO = 3'h4; // result low byte
	localparam logic [2:0] ADQ_OFF_RHI = 3'h5; // result high byte
	// default base address of the register block
	localparam logic [15:0] ADQ_BASE_DEF = 16'hF700;
	// command register bit positions
	localparam int ADQ_CMD_RUN = 0; // start/stop
	localparam int ADQ_CMD_SCAN = 1; // sequential scan
	localparam int ADQ_CMD_PACE = 2; // pacer starts enabled
	localparam int ADQ_CMD_TRIG = 3; // external trigger enabled
	localparam int ADQ_CMD_IEN = 4; // interrupt enable
	localparam int ADQ_CMD_IEOS = 5; // interrupt at end of scan only
	localparam int ADQ_CMD_GAIN = 6; // two-bit gain code, bits 7:6
	// status register bit positions
	localparam int ADQ_ST_BUSY = 0;
	localparam int ADQ_ST_DONE = 1;
	localparam int ADQ_ST_IRQ = 2;
	localparam int ADQ_ST_EOS = 3;
	// reset values
	localparam logic [7:0] ADQ_CMD_RST = 8'h00;
	localparam logic [7:0] ADQ_CHAN_RST = 8'h00;
	// timing: clock period and conversion time
	localparam int ADQ_CLK_NS = 40;
	localparam int ADQ_CONV_NS = 35000;
	localparam int ADQ_CONV_CYC = (ADQ_CONV_NS + ADQ_CLK_NS - 1) / ADQ_CLK_NS;
	// pacer: longest period in ms, divided by two to the n
	localparam int ADQ_PACER_MS = 1000;
	localparam int ADQ_PACER_CYC = ADQ_PACER_MS * (1000000 / ADQ_CLK_NS);
	localparam int ADQ_PACER_NMAX = 10;
endpackage : adq_pkg

// ===== rtl/adq_device_end.sv
// acquisition device end: registers, start logic, scan and interrupt
`timescale 1ns/1ps
module adq_device_end import adq_pkg::*; #(
	parameter logic [15:0] BASE_ADDR = ADQ_BASE_DEF,
	parameter int CHAN_W = 5,
	parameter int CONV_CYC = ADQ_CONV_CYC,
	parameter int PACER_CYC = ADQ_PACER_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// host bus
	adq_bus_if.device bus,
	// converter and multiplexer side
	input wire logic [11:0] adcResult,
	output logic sampleHold,
	output logic [CHAN_W-1:0] muxChannel,
	output logic [1:0] gainSel,
	// start sources and jumpers
	input wire logic extTrigger,
	input wire logic [3:0] pacerRange
);
	// selector spans 16 or 32 single-ended inputs
	if (CHAN_W < 4 || CHAN_W > 5) begin : g_chk_chan
		$error("channel width must be 4 or 5");
	end
	if (CONV_CYC < 2) begin : g_chk_conv
		$error("conversion count too small");
	end
	if (BASE_ADDR[2:0] != 3'h0) begin : g_chk_base
		$error("base address must be eight-byte aligned");
	end

	localparam int CNT_W = $clog2(CONV_CYC + 1);

	// one-hot conversion states
	typedef enum logic [1:0] {
		ADQ_IDLE = 2'b01, // waiting for a start
		ADQ_CONV = 2'b10 // holding and converting
	} adq_conv_t;

	typedef struct packed {
		adq_conv_t st; // conversion state
		logic [7:0] cmd; // acquisition_command
		logic [CHAN_W-1:0] chan; // input_channel_select
		logic [CHAN_W-1:0] last; // scan_end_channel
		logic [11:0] result; // conversion_result
		logic done; // result ready
		logic eos; // end of scan reached
		logic irqPend; // pending interrupt
		logic trigPrev; // trigger level last cycle
		logic [CNT_W-1:0] cnt; // conversion cycles left
		logic [7:0] rdata; // registered read data
	} adq_dev_state_t;

	adq_dev_state_t q_reg, q_next;

	// decoded bus strobes
	logic hit;
	logic [2:0] off;
	logic wrCmd, wrChan, wrLast, wrIclr, rdHi;
	logic trigRise, pacerTick;
	logic startReq, finish, lastConv, intEvent;
	logic [7:0] status;

	// true when the address lands in this block's window
	function automatic logic addr_hit(input logic [15:0] a);
		return a[15:3] == BASE_ADDR[15:3];
	endfunction : addr_hit

	// a bus write strobe aimed at one offset
	function automatic logic wr_at(input logic [2:0] o);
		return bus.wr && hit && off == o;
	endfunction : wr_at

	// pacer divider runs only while pacer starts are enabled
	adq_pacer #(
		.FULL_CYC(PACER_CYC)
	) u_pacer (
		.core_clk(core_clk),
		.reset(reset),
		.enable(q_reg.cmd[ADQ_CMD_PACE] && q_reg.cmd[ADQ_CMD_RUN]),
		.rangeSel(pacerRange),
		.tick(pacerTick)
	);

	// address decode
	assign hit = addr_hit(bus.addr);
	assign off = bus.addr[2:0];
	assign wrCmd = wr_at(ADQ_OFF_CMD);
	assign wrChan = wr_at(ADQ_OFF_CHAN);
	assign wrLast = wr_at(ADQ_OFF_LAST);
	assign wrIclr = wr_at(ADQ_OFF_ICLR);
	// reading the high byte ends a word read, so it restarts
	assign rdHi = bus.rd && hit && off == ADQ_OFF_RHI;

	// external trigger counts on its rising edge only
	assign trigRise = extTrigger && !q_reg.trigPrev;

	// non-command starts need the run bit; busy starts are dropped
	assign startReq = q_reg.cmd[ADQ_CMD_RUN] && (rdHi
		|| (q_reg.cmd[ADQ_CMD_PACE] && pacerTick)
		|| (q_reg.cmd[ADQ_CMD_TRIG] && trigRise));

	// conversion ends when the hold count runs out
	assign finish = q_reg.st == ADQ_CONV && q_reg.cnt == '0;
	assign lastConv = q_reg.cmd[ADQ_CMD_SCAN] && q_reg.chan == q_reg.last;
	// per-conversion or end-of-scan interrupt source
	assign intEvent = finish && q_reg.cmd[ADQ_CMD_IEN]
		&& (!q_reg.cmd[ADQ_CMD_IEOS] || lastConv);

	// status byte, upper bits read zero
	always_comb begin
		status = 8'h00;
		status[ADQ_ST_BUSY] = q_reg.st == ADQ_CONV;
		status[ADQ_ST_DONE] = q_reg.done;
		status[ADQ_ST_IRQ] = q_reg.irqPend;
		status[ADQ_ST_EOS] = q_reg.eos;
	end

	// next state
	always_comb begin
		q_next = q_reg;
		q_next.trigPrev = extTrigger;
		q_next.rdata = 8'h00; // read data stand one cycle only
		// conversion sequencer
		case (q_reg.st)
			ADQ_IDLE: begin
				if (startReq) begin
					q_next.st = ADQ_CONV;
					q_next.cnt = CNT_W'(CONV_CYC - 1);
					q_next.done = 1'b0;
				end
			end
			ADQ_CONV: begin
				if (q_reg.cnt != '0) begin
					q_next.cnt = q_reg.cnt - 1'b1;
				end else begin
					// take the held sample's code
					q_next.st = ADQ_IDLE;
					q_next.result = adcResult;
					q_next.done = 1'b1;
					if (lastConv) begin
						q_next.eos = 1'b1;
						q_next.cmd[ADQ_CMD_RUN] = 1'b0;
					end else if (q_reg.cmd[ADQ_CMD_SCAN]) begin
						q_next.chan = q_reg.chan + 1'b1;
					end
				end
			end
			default: begin
				q_next.st = ADQ_IDLE;
			end
		endcase
		// command write comes last so it overrides the sequencer
		if (wrCmd) begin
			q_next.cmd = bus.wdata;
			q_next.eos = 1'b0;
			if (bus.wdata[ADQ_CMD_RUN]) begin
				// restart even mid-conversion; old sample is dropped
				q_next.st = ADQ_CONV;
				q_next.cnt = CNT_W'(CONV_CYC - 1);
				q_next.done = 1'b0;
			end else begin
				q_next.st = ADQ_IDLE; // stop aborts any conversion
			end
		end
		// host channel write beats the scan increment
		if (wrChan) begin
			q_next.chan = bus.wdata[CHAN_W-1:0];
		end
		if (wrLast) begin
			q_next.last = bus.wdata[CHAN_W-1:0];
		end
		// clear first, so a same-cycle event still sets
		if (wrIclr) begin
			q_next.irqPend = 1'b0;
		end
		if (intEvent) begin
			q_next.irqPend = 1'b1;
		end
		// read mux; unmapped and write-only offsets read zero
		if (bus.rd && hit) begin
			case (off)
				ADQ_OFF_CMD: q_next.rdata = status;
				ADQ_OFF_CHAN: q_next.rdata = 8'(q_reg.chan);
				ADQ_OFF_RLO: q_next.rdata = {q_reg.result[3:0], 4'h0};
				ADQ_OFF_RHI: q_next.rdata = q_reg.result[11:4];
				default: q_next.rdata = 8'h00;
			endcase
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			q_reg <= '0;
			q_reg.st <= ADQ_IDLE;
			q_reg.cmd <= ADQ_CMD_RST;
			q_reg.chan <= ADQ_CHAN_RST[CHAN_W-1:0];
		end else begin
			q_reg <= q_next;
		end
	end

	// outputs
	assign bus.rdata = q_reg.rdata;
	assign bus.irq = q_reg.irqPend;
	assign sampleHold = q_reg.st == ADQ_CONV;
	assign muxChannel = q_reg.chan;
	assign gainSel = q_reg.cmd[ADQ_CMD_GAIN +: 2];
endmodule : adq_device_end

// ===== rtl/adq_host_end.sv
// host end: turns user requests into bus cycles
`timescale 1ns/1ps
module adq_host_end import adq_pkg::*; #(
	parameter logic [15:0] BASE_ADDR = ADQ_BASE_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// user request
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [2:0] cmdOffset,
	input wire logic [7:0] cmdData,
	output logic cmdReady,
	// user answer
	output logic respValid,
	output logic [7:0] respData,
	output logic userIrq,
	// bus to the device
	adq_bus_if.host bus
);
	if (BASE_ADDR[2:0] != 3'h0) begin : g_chk_base
		$error("base address must be eight-byte aligned");
	end

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic rdWait; // read data due this cycle
		logic respValid;
		logic [7:0] respData;
	} adq_host_state_t;

	adq_host_state_t q_reg, q_next;

	// the device never stalls, so every request is taken
	assign cmdReady = 1'b1;

	// next state: one bus cycle per request
	always_comb begin
		q_next = q_reg;
		q_next.wr = cmdValid && cmdWrite;
		q_next.rd = cmdValid && !cmdWrite;
		q_next.rdWait = q_reg.rd;
		q_next.respValid = q_reg.rdWait;
		if (cmdValid) begin
			q_next.addr = BASE_ADDR | 16'(cmdOffset);
			// channel write before result read is the caller's duty
			q_next.wdata = cmdWrite ? cmdData : 8'h00;
		end
		if (q_reg.rdWait) begin
			q_next.respData = bus.rdata;
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			q_reg <= '0;
			q_reg.addr <= BASE_ADDR;
		end else begin
			q_reg <= q_next;
		end
	end

	// outputs
	assign bus.addr = q_reg.addr;
	assign bus.wdata = q_reg.wdata;
	assign bus.wr = q_reg.wr;
	assign bus.rd = q_reg.rd;
	assign respValid = q_reg.respValid;
	assign respData = q_reg.respData;
	assign userIrq = bus.irq;
endmodule : adq_host_end

// ===== rtl/adq_pacer.sv
// crystal pacer: divides the core clock into start ticks
`timescale 1ns/1ps
module adq_pacer import adq_pkg::*; #(
	parameter int FULL_CYC = ADQ_PACER_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// control
	input wire logic enable,
	input wire logic [3:0] rangeSel,
	// output
	output logic tick
);
	if (FULL_CYC < 2048) begin : g_chk
		$error("pacer full count too small for ten ranges");
	end

	typedef struct packed {
		logic [31:0] cnt; // cycles in the current period
		logic tick; // one-cycle start pulse
	} adq_pacer_state_t;

	adq_pacer_state_t q_reg, q_next;
	logic [3:0] rangeClamp;
	logic [31:0] period;

	// ranges above the top one clamp rather than wrap
	assign rangeClamp = (rangeSel > 4'(ADQ_PACER_NMAX)) ? 4'(ADQ_PACER_NMAX) : rangeSel;
	assign period = 32'(FULL_CYC) >> rangeClamp;

	// next state: count, pulse and restart at period end
	always_comb begin
		q_next = q_reg;
		q_next.tick = 1'b0;
		if (!enable) begin
			q_next.cnt = 32'h0; // disabled pacer restarts from zero
		end else if (q_reg.cnt >= period - 32'h1) begin
			q_next.cnt = 32'h0;
			q_next.tick = 1'b1;
		end else begin
			q_next.cnt = q_reg.cnt + 32'h1;
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign tick = q_reg.tick;
endmodule : adq_pacer

// ===== sim/adq_bus_monitor.sv
// checker on the bus between host end and device end
`timescale 1ns/1ps
module adq_bus_monitor import adq_pkg::*; #(
	parameter logic [15:0] BASE_ADDR = ADQ_BASE_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// bus signals
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// register offset of the current cycle
	logic [2:0] off;
	assign off = addr[2:0];
	a_one_strobe: assert property (!(wr && rd))
		else $error("both strobes high");
	a_base_only: assert property ((wr || rd) |-> addr[15:3] == BASE_ADDR[15:3])
		else $error("access off base");
	a_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not idle");
	a_wo_zero: assert property (rd && off inside {3'h2, 3'h3, 3'h6, 3'h7} |=> rdata == 8'h00)
		else $error("write-only place read nonzero");
	a_low_nibble: assert property (rd && off == ADQ_OFF_RLO |=> rdata[3:0] == 4'h0)
		else $error("low nibble not zero");
	// a conversion end in the clear cycle keeps irq set; the bench keeps them apart
	a_clear_irq: assert property (wr && off == ADQ_OFF_ICLR |-> ##[1:2] !irq)
		else $error("irq not cleared");
	a_start_busy: assert property (wr && off == 0 && wdata[ADQ_CMD_RUN] ##1 rd && off == 0
		|=> rdata[ADQ_ST_BUSY] && !rdata[ADQ_ST_EOS]) else $error("start not busy");
	a_stop_idle: assert property (wr && off == 0 && !wdata[ADQ_CMD_RUN] ##1 rd && off == 0
		|=> !rdata[ADQ_ST_BUSY]) else $error("stop left busy");
	c_start: cover property (wr && off == ADQ_OFF_CMD && wdata[ADQ_CMD_RUN]);
	c_irq: cover property ($rose(irq));
	c_hi: cover property (rd && off == ADQ_OFF_RHI);
endmodule : adq_bus_monitor

// ===== sim/tb_analog_input_acquisition_control.sv
// bench joining host end and device end
`timescale 1ns/1ps
module tb_analog_input_acquisition_control import adq_pkg::*;;
	localparam int PACE = 4096; // shortened pacer count
	localparam int CONV = 8; // shortened conversion count
	logic core_clk = 0, reset = 1;
	logic cmdValid = 0, cmdWrite = 0, cmdReady, respValid, userIrq, sampleHold, extTrigger = 0;
	logic [2:0] cmdOffset = 0;
	logic [7:0] cmdData = 0, respData;
	logic [11:0] adcResult = 0;
	logic [4:0] muxChannel;
	logic [1:0] gainSel;
	logic [3:0] pacerRange = 4'hA;
	logic [31:0] r;
	int miscompares = 0, n_compared = 0, seed = 38, i;
	logic shPrev = 0; // sampleHold one edge ago
	adq_bus_if bus ();
	always #20 core_clk = ~core_clk;
	// delayed copy for start detection
	always @(posedge core_clk) shPrev <= sampleHold;
	adq_host_end adq_host_end_inst (.core_clk(core_clk), .reset(reset), .cmdValid(cmdValid),
		.cmdWrite(cmdWrite), .cmdOffset(cmdOffset), .cmdData(cmdData), .cmdReady(cmdReady),
		.respValid(respValid), .respData(respData), .userIrq(userIrq), .bus(bus));
	adq_device_end #(.CONV_CYC(CONV), .PACER_CYC(PACE)) adq_device_end_inst (.core_clk(core_clk),
		.reset(reset), .bus(bus), .adcResult(adcResult), .sampleHold(sampleHold),
		.muxChannel(muxChannel), .gainSel(gainSel), .extTrigger(extTrigger), .pacerRange(pacerRange));
	adq_bus_monitor adq_bus_monitor_inst (.core_clk(core_clk), .reset(reset), .addr(bus.addr),
		.wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .irq(bus.irq));
	// expected result byte, left-justified
	function automatic logic [7:0] jus(input logic [11:0] v, input logic hi);
		return hi ? v[11:4] : {v[3:0], 4'h0};
	endfunction : jus
	// start spacing: first pacer tick that finds the converter idle again
	function automatic int pgap(input int p);
		return ((CONV + p) / p) * p;
	endfunction : pgap
	// cycles between the next two rises of sampleHold
	task automatic gap(input int exp);
		int n;
		int t;
		n = 0;
		t = 0;
		for (int k = 0; k < 200 && n < 2; k++) begin
			@(posedge core_clk);
			if (n == 1) t++;
			if (sampleHold === 1'b1 && shPrev === 1'b0) n++;
		end
		#1;
		chk(8'(t), 8'(exp));
	endtask : gap
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// request held one cycle, left up for back-to-back use
	task automatic acc(input logic w, input logic [2:0] o, input logic [7:0] d);
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmdWrite <= w;
		cmdOffset <= o;
		cmdData <= d;
	endtask : acc
	task automatic idle(input int n);
		@(posedge core_clk);
		cmdValid <= 1'b0;
		repeat (n) @(posedge core_clk);
		#1;
	endtask : idle
	task automatic put(input logic [2:0] o, input logic [7:0] d);
		acc(1'b1, o, d);
		idle(1);
	endtask : put
	// answer is due three cycles after the request
	task automatic rdx(input logic [2:0] o, input logic [7:0] e);
		acc(1'b0, o, 8'h00);
		idle(2);
		chk({7'h00, respValid}, 8'h01);
		chk(respData, e);
	endtask : rdx
	task automatic waitConv();
		for (int k = 0; k < 50 && sampleHold === 1'b1; k++) @(posedge core_clk);
		repeat (2) @(posedge core_clk);
		#1;
	endtask : waitConv
	task automatic up(input int lim);
		for (int k = 0; k < lim && sampleHold !== 1'b1; k++) @(posedge core_clk);
		#1;
		chk({7'h00, sampleHold}, 8'h01);
	endtask : up
	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	// hang guard, well past the expected run
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		results();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		for (i = 0; i < 8; i++) if (i != 4 && i != 5) rdx(i[2:0], 8'h00);
		for (i = 0; i < 4; i++) begin
			put(ADQ_OFF_CMD, {i[1:0], 6'h00});
			chk({6'h00, gainSel}, {6'h00, i[1:0]});
		end
		for (i = 0; i < 3; i++) begin
			r = $random(seed);
			put(ADQ_OFF_CHAN, {3'h0, r[4:0]});
			chk({3'h0, muxChannel}, {3'h0, r[4:0]});
			rdx(ADQ_OFF_CHAN, {3'h0, r[4:0]});
		end
		chk({7'h00, cmdReady}, 8'h01);
		$display("registers done");
		r = $random(seed);
		@(posedge core_clk);
		adcResult <= r[11:0];
		acc(1'b1, ADQ_OFF_CMD, 8'h11);
		rdx(ADQ_OFF_CMD, 8'h01);
		waitConv();
		rdx(ADQ_OFF_CMD, 8'h06);
		rdx(ADQ_OFF_RLO, jus(r[11:0], 1'b0));
		rdx(ADQ_OFF_RHI, jus(r[11:0], 1'b1));
		chk({7'h00, sampleHold}, 8'h01);
		acc(1'b1, ADQ_OFF_CMD, 8'h00);
		rdx(ADQ_OFF_CMD, 8'h04);
		put(ADQ_OFF_ICLR, 8'hFF);
		chk({7'h00, userIrq}, 8'h00);
		$display("single done");
		put(ADQ_OFF_LAST, 8'h03);
		put(ADQ_OFF_CHAN, 8'h01);
		put(ADQ_OFF_CMD, 8'h33);
		for (i = 1; i < 4; i++) begin
			waitConv();
			chk({3'h0, muxChannel}, (i < 3) ? i[7:0] + 8'h01 : 8'h03);
			if (i < 3) begin
				chk({7'h00, userIrq}, 8'h00);
				rdx(ADQ_OFF_RHI, jus(r[11:0], 1'b1));
			end
		end
		rdx(ADQ_OFF_CMD, 8'h0E);
		put(ADQ_OFF_ICLR, 8'h00);
		$display("scan done");
		// random channel: next channel goes in before the result read restarts
		put(ADQ_OFF_CMD, 8'h01);
		for (i = 0; i < 2; i++) begin
			waitConv();
			r = $random(seed);
			put(ADQ_OFF_CHAN, {3'h0, r[4:0]});
			rdx(ADQ_OFF_RHI, jus(adcResult, 1'b1));
			chk({3'h0, muxChannel}, {3'h0, r[4:0]});
			chk({7'h00, sampleHold}, 8'h01);
		end
		$display("random done");
		put(ADQ_OFF_CMD, 8'h09);
		waitConv();
		chk({7'h00, sampleHold}, 8'h00);
		@(posedge core_clk);
		extTrigger <= 1'b1;
		@(posedge core_clk);
		extTrigger <= 1'b0;
		up(6);
		for (i = 8; i < 11; i++) begin
			@(posedge core_clk);
			pacerRange <= i[3:0];
			put(ADQ_OFF_CMD, 8'h05);
			waitConv();
			up((PACE >> i) + 6);
			gap(pgap(PACE >> i));
		end
		put(ADQ_OFF_CMD, 8'h00);
		$display("starts done");
		results();
	end
endmodule : tb_analog_input_acquisition_control
